//--- adccfg_regs.sv
// Functional notes
// R1 - freeze code 111 holds last offset correction
// R2 - software writes 011 freeze code after power-up
// R3 - software always writes ones to bits 5,1
// R4 - offset disable bit stops correction entirely
// R5 - four-bit gain, 1 dB steps, max 11
// R6 - gain registers sit in per-channel pages
// R7 - low-high-low core bit resets both channels
// R8 - zone settings apply only on core reset
// R9 - zone enable bit gates zone specification
// R10 - software sets zone enable before zone select
// R11 - three-bit zone select drives correction loop
// R12 - channel a main page holds reset, zone
// R13 - channel b main page mirrors reset, zone
// R14 - reserved bits written zero, no effect
//
// top of the dual-channel digital configuration register bank
// assumes a plain strobe port from software on the same clock
`timescale 1ns/1ps
module adccfg_regs
	import adccfg_pkg::*;
(
	input  wire logic                             clk_i,
	input  wire logic                             resetn_i,
	input  wire logic [ADDR_W-1:0]                addr_i,
	input  wire logic [DATA_W-1:0]                wdata_i,
	input  wire logic                             wr_i,
	input  wire logic                             rd_i,
	output logic      [DATA_W-1:0]                rdata_o,
	output logic      [NCHAN-1:0]                 offset_hold_o,
	output logic      [NCHAN-1:0]                 corr_enable_o,
	output logic      [NCHAN-1:0][GAIN_W-1:0]     gain_code_o,
	output logic      [NCHAN-1:0]                 zone_enable_o,
	output logic      [NCHAN-1:0][ZONE_SEL_W-1:0] zone_sel_o,
	output logic                                  core_reset_o
);

	logic [PAGE_W-1:0]             page;
	logic [OFS_W-1:0]              ofs;
	logic [NCHAN-1:0]              sel_ofs;
	logic [NCHAN-1:0]              sel_gain;
	logic [NCHAN-1:0]              sel_zone;
	logic [NCHAN-1:0]              sel_zstat;
	logic [NCHAN-1:0]              sel_crst;
	logic [NCHAN-1:0]              crst_bits;
	logic [NCHAN-1:0][DATA_W-1:0]  ofs_q;
	logic [NCHAN-1:0][DATA_W-1:0]  gain_q;
	logic [NCHAN-1:0][DATA_W-1:0]  zone_q;
	logic [NCHAN-1:0][DATA_W-1:0]  zact_q;
	logic [NCHAN-1:0][PAGE_W-1:0]  page_ofs;
	logic [NCHAN-1:0][PAGE_W-1:0]  page_gain;
	logic [NCHAN-1:0][PAGE_W-1:0]  page_main;
	logic                          core_pulse;
	logic [DATA_W-1:0]             rd_mux;
	logic                          hit;
	logic [DATA_W-1:0]             rdata_r;

	assign page = addr_i[ADDR_W-1:OFS_W];
	assign ofs  = addr_i[OFS_W-1:0];

	assign page_ofs  = {PAGE_OFSCOR_B, PAGE_OFSCOR_A};
	assign page_gain = {PAGE_GAIN_B, PAGE_GAIN_A}; // [R6]
	assign page_main = {PAGE_MAIN_B, PAGE_MAIN_A};

	genvar g;
	generate
		for (g = 0; g < NCHAN; g++) begin : g_ch
			assign sel_ofs[g]   = (page == page_ofs[g])  && (ofs == REG_OFSCOR_CTRL);
			assign sel_gain[g]  = (page == page_gain[g]) && (ofs == REG_GAIN_CTRL); // [R6]
			// both main pages hold the same three registers [R12] [R13]
			assign sel_zone[g]  = (page == page_main[g]) && (ofs == REG_ZONE_CTRL);
			assign sel_zstat[g] = (page == page_main[g]) && (ofs == REG_ZONE_STAT);
			assign sel_crst[g]  = (page == page_main[g]) && (ofs == REG_CORE_RESET);

			adccfg_chan u_chan (
				.clk_i       (clk_i),
				.resetn_i    (resetn_i),
				.we_ofs_i    (wr_i && sel_ofs[g]),
				.we_gain_i   (wr_i && sel_gain[g]),
				.we_zone_i   (wr_i && sel_zone[g]),
				.apply_i     (core_pulse),
				.wdata_i     (wdata_i),
				.ofs_o       (ofs_q[g]),
				.gain_o      (gain_q[g]),
				.zone_o      (zone_q[g]),
				.zone_act_o  (zact_q[g]),
				.hold_o      (offset_hold_o[g]),
				.corr_en_o   (corr_enable_o[g]),
				.gain_code_o (gain_code_o[g]),
				.zone_en_o   (zone_enable_o[g]),
				.zone_sel_o  (zone_sel_o[g])
			);
		end
	endgenerate

	// one detector serves both pages since the reset is global [R7]
	adccfg_rstpulse u_rst (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.we_i     ({NCHAN{wr_i}} & sel_crst),
		.wbit_i   (wdata_i[CRST_BIT]),
		.bit_o    (crst_bits),
		.pulse_o  (core_pulse)
	);

	assign core_reset_o = core_pulse;

	// read mux; the status register shows the zone settings in force
	always_comb begin
		rd_mux = '0;
		hit    = 1'b0;
		for (int i = 0; i < NCHAN; i++) begin
			if (sel_ofs[i]) begin
				rd_mux = ofs_q[i];
				hit    = 1'b1;
			end
			if (sel_gain[i]) begin
				rd_mux = gain_q[i];
				hit    = 1'b1;
			end
			if (sel_zone[i]) begin
				rd_mux = zone_q[i];
				hit    = 1'b1;
			end
			if (sel_zstat[i]) begin
				rd_mux = zact_q[i];
				hit    = 1'b1;
			end
			if (sel_crst[i]) begin
				rd_mux = {{(DATA_W-1){1'b0}}, crst_bits[i]};
				hit    = 1'b1;
			end
		end
	end

	// read data stand only in the cycle after the strobe; misses read zero
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			rdata_r <= RESET_VAL;
		end else if (rd_i && hit) begin
			rdata_r <= rd_mux;
		end else begin
			rdata_r <= RESET_VAL;
		end
	end

	assign rdata_o = rdata_r;

	// ---- checks ----

	sequence s_crst_set;
		wr_i && (|sel_crst) && wdata_i[CRST_BIT];
	endsequence

	sequence s_crst_clr;
		wr_i && (|sel_crst) && !wdata_i[CRST_BIT];
	endsequence

	sequence s_freeze_wr(int ch);
		wr_i && sel_ofs[ch] && (wdata_i & MASK_OFSCOR) == 8'ha2;
	endsequence

	property p_freeze(int ch);
		@(posedge clk_i) disable iff (!resetn_i)
		s_freeze_wr(ch) ##1 (!(wr_i && sel_ofs[ch]))
			|-> ##1 offset_hold_o[ch] && corr_enable_o[ch];
	endproperty

	generate
		for (g = 0; g < NCHAN; g++) begin : g_chk
			a_hold_freeze: assert property (p_freeze(g)) // [R1]
				else $error("freeze code did not hold the corrector");

			a_disable_corr: assert property ( // [R4]
				@(posedge clk_i) disable iff (!resetn_i)
				wr_i && sel_ofs[g] && wdata_i[OFS_DIS_BIT]
					##1 !(wr_i && sel_ofs[g])
					|-> ##1 !corr_enable_o[g] && !offset_hold_o[g])
				else $error("disable bit did not stop correction");

			a_gain_range: assert property ( // [R5]
				@(posedge clk_i) disable iff (!resetn_i)
				gain_code_o[g] <= GAIN_MAX)
				else $error("gain code beyond top step");

			a_gain_apply: assert property ( // [R5]
				@(posedge clk_i) disable iff (!resetn_i)
				wr_i && sel_gain[g] && wdata_i[GAIN_W-1:0] <= GAIN_MAX
					##1 !(wr_i && sel_gain[g])
					|-> ##1 gain_code_o[g] == $past(wdata_i[GAIN_W-1:0], 2))
				else $error("gain code not applied");

			a_zone_wait: assert property ( // [R8]
				@(posedge clk_i) disable iff (!resetn_i)
				!$past(core_reset_o) && !$past(core_reset_o, 2)
					|-> $stable(zone_sel_o[g]) && $stable(zone_enable_o[g]))
				else $error("zone changed without core reset");

			a_zone_gate: assert property ( // [R9]
				@(posedge clk_i) disable iff (!resetn_i)
				!zone_enable_o[g] |-> zone_sel_o[g] == '0)
				else $error("zone select active while disabled");

			a_zone_take: assert property ( // [R8]
				@(posedge clk_i) disable iff (!resetn_i)
				core_reset_o && !(wr_i && sel_zone[g])
					|-> ##2 zone_enable_o[g] == $past(zone_q[g][ZONE_EN_BIT], 2))
				else $error("pending zone not taken on core reset");
		end
	endgenerate

	a_rst_pulse: assert property ( // [R7]
		@(posedge clk_i) disable iff (!resetn_i)
		s_crst_set ##1 s_crst_clr ##1 (!(wr_i && (|sel_crst)))
			|-> ##[0:2] core_reset_o)
		else $error("core reset pulse not produced");

	a_rst_single: assert property ( // [R7]
		@(posedge clk_i) disable iff (!resetn_i)
		core_reset_o |=> !core_reset_o)
		else $error("core reset longer than one cycle");

	a_rst_cause: assert property ( // [R7]
		@(posedge clk_i) disable iff (!resetn_i)
		core_reset_o |-> $past(crst_bits == '0) && $past(crst_bits != '0, 2))
		else $error("core reset without falling bit");

	a_read_idle: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		!(rd_i && hit) |=> rdata_o == '0)
		else $error("read data outside read cycle");

	a_reserved_zero: assert property ( // [R14]
		@(posedge clk_i) disable iff (!resetn_i)
		rd_i && (|sel_ofs) |=> (rdata_o & ~MASK_OFSCOR) == '0)
		else $error("reserved bits read non-zero");

	a_zone_read: assert property ( // [R12]
		@(posedge clk_i) disable iff (!resetn_i)
		wr_i && sel_zone[0] ##1 rd_i && sel_zone[0] && !wr_i
			|=> rdata_o == ($past(wdata_i, 2) & MASK_ZONE))
		else $error("zone register readback wrong");

endmodule

//--- adccfg_pkg.sv
// constants, field layouts and the reset-pulse state type for the per-channel
// converter configuration register bank
// assumes a 32-bit register space addressed as {page, offset}
package adccfg_pkg;

	localparam int unsigned NCHAN      = 2;
	localparam int unsigned PAGE_W     = 24;
	localparam int unsigned OFS_W      = 8;
	localparam int unsigned ADDR_W     = PAGE_W + OFS_W;
	localparam int unsigned DATA_W     = 8;

	// page codes, index 0 is channel a, index 1 is channel b
	localparam logic [PAGE_W-1:0] PAGE_OFSCOR_A = 24'h610000;
	localparam logic [PAGE_W-1:0] PAGE_OFSCOR_B = 24'h610100;
	localparam logic [PAGE_W-1:0] PAGE_GAIN_A   = 24'h610005;
	localparam logic [PAGE_W-1:0] PAGE_GAIN_B   = 24'h610105;
	localparam logic [PAGE_W-1:0] PAGE_MAIN_A   = 24'h680000;
	localparam logic [PAGE_W-1:0] PAGE_MAIN_B   = 24'h680001;

	// register offsets within a page
	localparam logic [OFS_W-1:0] REG_CORE_RESET  = 8'h00;
	localparam logic [OFS_W-1:0] REG_OFSCOR_CTRL = 8'h68;
	localparam logic [OFS_W-1:0] REG_ZONE_CTRL   = 8'ha2;
	localparam logic [OFS_W-1:0] REG_ZONE_STAT   = 8'ha3;
	localparam logic [OFS_W-1:0] REG_GAIN_CTRL   = 8'ha6;

	// writable bits per register, reserved bits are dropped and read zero
	localparam logic [DATA_W-1:0] MASK_OFSCOR = 8'ha6;
	localparam logic [DATA_W-1:0] MASK_GAIN   = 8'h0f;
	localparam logic [DATA_W-1:0] MASK_ZONE   = 8'h0f;
	localparam logic [DATA_W-1:0] MASK_CRST   = 8'h01;
	localparam logic [DATA_W-1:0] RESET_VAL   = 8'h00;

	// field positions
	localparam int unsigned OFS_FREEZE_BIT = 7;
	localparam int unsigned OFS_KEEP_HI    = 5;
	localparam int unsigned OFS_DIS_BIT    = 2;
	localparam int unsigned OFS_KEEP_LO    = 1;
	localparam int unsigned CRST_BIT       = 0;
	localparam int unsigned ZONE_EN_BIT    = 3;
	localparam int unsigned ZONE_SEL_W     = 3;
	localparam int unsigned GAIN_W         = 4;

	localparam logic [2:0]        HOLD_CODE = 3'b111;
	localparam logic [GAIN_W-1:0] GAIN_MAX  = 4'hb;

	typedef enum logic [0:0] {
		RST_IDLE  = 1'b0,
		RST_ARMED = 1'b1
	} adccfg_rst_st_t;

endpackage

//--- adccfg_rstpulse.sv
// core reset bit of both main pages and the detector of its low-high-low pulse
// assumes write enables come from the decoder on the same clock
`timescale 1ns/1ps
module adccfg_rstpulse
	import adccfg_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             resetn_i,
	input  wire logic [NCHAN-1:0] we_i,
	input  wire logic             wbit_i,
	output logic      [NCHAN-1:0] bit_o,
	output logic                  pulse_o
);

	logic [NCHAN-1:0] bit_r;
	adccfg_rst_st_t   st_r;
	adccfg_rst_st_t   st_nxt;
	logic             pulse_r;

	genvar g;
	generate
		for (g = 0; g < NCHAN; g++) begin : g_bit
			always_ff @(posedge clk_i) begin
				if (!resetn_i) begin
					bit_r[g] <= 1'b0;
				end else if (we_i[g]) begin
					bit_r[g] <= wbit_i;
				end
			end
		end
	endgenerate

	// either page's bit starts the pulse; the core resets when both pages' bits are low again
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			RST_IDLE:  if (|bit_r) st_nxt = RST_ARMED;
			RST_ARMED: if (!(|bit_r)) st_nxt = RST_IDLE;
			default:   st_nxt = RST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			st_r <= RST_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			pulse_r <= 1'b0;
		end else begin
			pulse_r <= (st_r == RST_ARMED) && !(|bit_r); // [R7]
		end
	end

	assign bit_o   = bit_r;
	assign pulse_o = pulse_r;

endmodule

//--- adccfg_chan.sv
// one channel's offset, gain and zone registers with their registered controls
// assumes apply_i is the one-cycle core reset pulse
`timescale 1ns/1ps
module adccfg_chan
	import adccfg_pkg::*;
(
	input  wire logic                  clk_i,
	input  wire logic                  resetn_i,
	input  wire logic                  we_ofs_i,
	input  wire logic                  we_gain_i,
	input  wire logic                  we_zone_i,
	input  wire logic                  apply_i,
	input  wire logic [DATA_W-1:0]     wdata_i,
	output logic      [DATA_W-1:0]     ofs_o,
	output logic      [DATA_W-1:0]     gain_o,
	output logic      [DATA_W-1:0]     zone_o,
	output logic      [DATA_W-1:0]     zone_act_o,
	output logic                       hold_o,
	output logic                       corr_en_o,
	output logic      [GAIN_W-1:0]     gain_code_o,
	output logic                       zone_en_o,
	output logic      [ZONE_SEL_W-1:0] zone_sel_o
);

	logic [DATA_W-1:0] ofs_r;
	logic [DATA_W-1:0] gain_r;
	logic [DATA_W-1:0] zone_r;
	logic [DATA_W-1:0] zone_act_r;
	logic [2:0]        hold_bits;

	// reserved positions never reach a flop, so they have no effect [R14]
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			ofs_r  <= RESET_VAL;
			gain_r <= RESET_VAL;
			zone_r <= RESET_VAL;
		end else begin
			if (we_ofs_i)  ofs_r  <= wdata_i & MASK_OFSCOR;
			if (we_gain_i) gain_r <= wdata_i & MASK_GAIN;
			if (we_zone_i) zone_r <= wdata_i & MASK_ZONE;
		end
	end

	// zone settings wait for the core reset pulse [R8]
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			zone_act_r <= RESET_VAL;
		end else if (apply_i) begin
			zone_act_r <= zone_r;
		end
	end

	assign hold_bits = {ofs_r[OFS_FREEZE_BIT], ofs_r[OFS_KEEP_HI], ofs_r[OFS_KEEP_LO]};

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			hold_o      <= 1'b0;
			corr_en_o   <= 1'b0;
			gain_code_o <= '0;
			zone_en_o   <= 1'b0;
			zone_sel_o  <= '0;
		end else begin
			// unused freeze codes are taken as running
			hold_o      <= (hold_bits == HOLD_CODE) && !ofs_r[OFS_DIS_BIT]; // [R1]
			corr_en_o   <= !ofs_r[OFS_DIS_BIT]; // [R4]
			// unused codes above the top step saturate rather than wrap
			gain_code_o <= (gain_r[GAIN_W-1:0] > GAIN_MAX) ? GAIN_MAX
			                                              : gain_r[GAIN_W-1:0]; // [R5]
			zone_en_o   <= zone_act_r[ZONE_EN_BIT]; // [R9]
			zone_sel_o  <= zone_act_r[ZONE_EN_BIT] ? zone_act_r[ZONE_SEL_W-1:0]
			                                       : '0; // [R11]
		end
	end

	assign ofs_o      = ofs_r;
	assign gain_o     = gain_r;
	assign zone_o     = zone_r;
	assign zone_act_o = zone_act_r;

endmodule

//--- adccfg_regs_tb_top.sv
// self-checking bench for the dual-channel configuration register bank
// assumes the bank's own assertions and a plain strobe register port
`timescale 1ns/1ps
module adccfg_regs_tb_top
	import adccfg_pkg::*;
();
	logic                             clk_i;
	logic                             resetn_i;
	logic [ADDR_W-1:0]                addr_i;
	logic [DATA_W-1:0]                wdata_i;
	logic                             wr_i;
	logic                             rd_i;
	logic [DATA_W-1:0]                rdata_o;
	logic [NCHAN-1:0]                 offset_hold_o;
	logic [NCHAN-1:0]                 corr_enable_o;
	logic [NCHAN-1:0][GAIN_W-1:0]     gain_code_o;
	logic [NCHAN-1:0]                 zone_enable_o;
	logic [NCHAN-1:0][ZONE_SEL_W-1:0] zone_sel_o;
	logic                             core_reset_o;
	int                               error_cnt;
	int                               comparisons;
	int unsigned                      seed;
	logic [PAGE_W-1:0]                pg_ofs [NCHAN];
	logic [PAGE_W-1:0]                pg_gain [NCHAN];
	logic [PAGE_W-1:0]                pg_main [NCHAN];
	logic [DATA_W-1:0]                ofs_exp [NCHAN];
	logic [GAIN_W-1:0]                gain_exp [NCHAN];
	logic                             zen_exp [NCHAN];
	logic [ZONE_SEL_W-1:0]            zsel_exp [NCHAN];
	logic [DATA_W-1:0]                rv;

	adccfg_regs dut (
		.clk_i         (clk_i),
		.resetn_i      (resetn_i),
		.addr_i        (addr_i),
		.wdata_i       (wdata_i),
		.wr_i          (wr_i),
		.rd_i          (rd_i),
		.rdata_o       (rdata_o),
		.offset_hold_o (offset_hold_o),
		.corr_enable_o (corr_enable_o),
		.gain_code_o   (gain_code_o),
		.zone_enable_o (zone_enable_o),
		.zone_sel_o    (zone_sel_o),
		.core_reset_o  (core_reset_o)
	);

	always #25 clk_i = ~clk_i;

	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp,
		input string what);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("mismatches %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic wr(input logic [PAGE_W-1:0] pg, input logic [OFS_W-1:0] ofs,
		input logic [DATA_W-1:0] d);
		@(posedge clk_i);
		wr_i    <= 1'b1;
		addr_i  <= {pg, ofs};
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	// read data is valid only in the cycle after the strobe, zero after that
	task automatic rd(input logic [PAGE_W-1:0] pg, input logic [OFS_W-1:0] ofs,
		output logic [DATA_W-1:0] d);
		@(posedge clk_i);
		rd_i   <= 1'b1;
		addr_i <= {pg, ofs};
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		d = rdata_o;
		@(negedge clk_i);
		check(rdata_o, 8'h00, "read data held too long");
	endtask

	task automatic settle;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
	endtask

	function automatic logic exp_hold(input logic [DATA_W-1:0] d);
		return d[7] & d[5] & d[1] & ~d[2];
	endfunction

	// codes above the maximum are out of range, the bank clamps them
	function automatic logic [GAIN_W-1:0] exp_gain(input logic [GAIN_W-1:0] c);
		return (c > GAIN_MAX) ? GAIN_MAX : c;
	endfunction

	task automatic check_outs;
		for (int ch = 0; ch < NCHAN; ch++) begin
			check({7'h0, offset_hold_o[ch]}, {7'h0, exp_hold(ofs_exp[ch])}, "hold");
			check({7'h0, corr_enable_o[ch]}, {7'h0, ~ofs_exp[ch][2]}, "corr enable");
			check({4'h0, gain_code_o[ch]}, {4'h0, exp_gain(gain_exp[ch])}, "gain");
			check({7'h0, zone_enable_o[ch]}, {7'h0, zen_exp[ch]}, "zone enable");
			check({5'h0, zone_sel_o[ch]}, {5'h0, zen_exp[ch] ? zsel_exp[ch] : 3'h0}, "zone");
		end
	endtask

	task automatic reset_values;
		for (int ch = 0; ch < NCHAN; ch++) begin
			ofs_exp[ch]  = 8'h00;
			gain_exp[ch] = 4'h0;
			zen_exp[ch]  = 1'b0;
			zsel_exp[ch] = 3'h0;
			rd(pg_ofs[ch], REG_OFSCOR_CTRL, rv);
			check(rv, RESET_VAL, "offset reset value");
			rd(pg_gain[ch], REG_GAIN_CTRL, rv);
			check(rv, RESET_VAL, "gain reset value");
			rd(pg_main[ch], REG_CORE_RESET, rv);
			check(rv, RESET_VAL, "core reset value");
			rd(pg_main[ch], REG_ZONE_CTRL, rv);
			check(rv, RESET_VAL, "zone reset value");
		end
		settle();
		check_outs();
	endtask

	initial begin
		repeat (60000) @(posedge clk_i);
		error_cnt++;
		$display("[FAIL] %0t run did not finish in time", $time);
		report_and_stop();
	end

	initial begin
		int ch;
		int c;
		logic [DATA_W-1:0] d;
		clk_i       = 1'b0;
		resetn_i    = 1'b0;
		addr_i      = '0;
		wdata_i     = '0;
		wr_i        = 1'b0;
		rd_i        = 1'b0;
		error_cnt   = 0;
		comparisons = 0;
		pg_ofs      = '{PAGE_OFSCOR_A, PAGE_OFSCOR_B};
		pg_gain     = '{PAGE_GAIN_A, PAGE_GAIN_B};
		pg_main     = '{PAGE_MAIN_A, PAGE_MAIN_B};
		seed        = $urandom(25);
		repeat (3) @(posedge clk_i);
		resetn_i <= 1'b1;
		reset_values();
		// offset control: corners first, then random with the mandatory ones kept
		for (int i = 0; i < 24; i++) begin
			ch = i % 2;
			d  = (i < 8) ? 8'h22 : (8'($urandom()) | 8'h22);
			if (i >= 2 && i < 4) d = 8'ha2;
			if (i >= 4 && i < 6) d = 8'ha6;
			if (i >= 6 && i < 8) d = 8'hff;
			wr(pg_ofs[ch], REG_OFSCOR_CTRL, d);
			ofs_exp[ch] = d & MASK_OFSCOR;
			settle();
			check_outs();
			rd(pg_ofs[ch], REG_OFSCOR_CTRL, rv);
			check(rv, ofs_exp[ch], "offset readback");
		end
		// every gain code on a random channel, reserved nibble sometimes set
		for (int code = 0; code < 16; code++) begin
			ch = $urandom() % 2;
			d  = {($urandom() % 2) ? 4'hf : 4'h0, 4'(code)};
			wr(pg_gain[ch], REG_GAIN_CTRL, d);
			gain_exp[ch] = 4'(code);
			settle();
			check_outs();
			rd(pg_gain[ch], REG_GAIN_CTRL, rv);
			check(rv, d & MASK_GAIN, "gain readback");
		end
		// unmapped places: writes dropped, reads zero
		wr(PAGE_GAIN_A, 8'h10, 8'hff);
		wr(24'h610205, REG_GAIN_CTRL, 8'h03);
		rd(PAGE_GAIN_A, 8'h10, rv);
		check(rv, 8'h00, "unmapped read");
		settle();
		check_outs();
		// zone settings wait for the low-high-low core reset pulse
		for (int i = 0; i < 8; i++) begin
			logic                  pen [NCHAN];
			logic [ZONE_SEL_W-1:0] psel [NCHAN];
			for (ch = 0; ch < NCHAN; ch++) begin
				pen[ch]  = (i != 2);
				psel[ch] = (i < 4) ? 3'(i ^ ch) : 3'($urandom() % 4);
				if (pen[ch]) wr(pg_main[ch], REG_ZONE_CTRL, 8'h08);
				wr(pg_main[ch], REG_ZONE_CTRL, {4'h0, pen[ch], psel[ch]});
				rd(pg_main[ch], REG_ZONE_CTRL, rv);
				check(rv, {4'h0, pen[ch], psel[ch]}, "zone readback");
			end
			settle();
			check_outs();
			c = i % 2;
			wr(pg_main[c], REG_CORE_RESET, 8'h01);
			rd(pg_main[c], REG_CORE_RESET, rv);
			check(rv, 8'h01, "core reset bit");
			check({7'h0, core_reset_o}, 8'h00, "pulse before clear");
			wr(pg_main[c], REG_CORE_RESET, 8'h00);
			@(negedge clk_i);
			check({7'h0, core_reset_o}, 8'h00, "pulse early");
			@(negedge clk_i);
			check({7'h0, core_reset_o}, 8'h01, "pulse missing");
			check_outs();
			@(negedge clk_i);
			check({7'h0, core_reset_o}, 8'h00, "pulse too long");
			@(negedge clk_i);
			for (ch = 0; ch < NCHAN; ch++) begin
				zen_exp[ch]  = pen[ch];
				zsel_exp[ch] = psel[ch];
			end
			check_outs();
		end
		// second reset in mid-run brings everything back to its defaults
		@(posedge clk_i);
		resetn_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		resetn_i <= 1'b1;
		reset_values();
		report_and_stop();
	end
endmodule
